// ==== rtl/ipcc_map.vh ====
// Purpose: constants of the inline packet crypto control block
// Assumes: included by bare name from the design files under rtl/
// Notes: definitions only; register offsets are byte addresses
`ifndef IPCC_MAP_VH
`define IPCC_MAP_VH

// register offsets
`define IPCC_A_EVENT 8'h00
`define IPCC_A_MASK 8'h04
`define IPCC_A_STATE 8'h08
`define IPCC_A_WRAP_SALT 8'h0C
`define IPCC_A_ADD_LO 8'h10
`define IPCC_A_ADD_HI 8'h14

// event bit positions in EVENT and MASK
`define IPCC_EV_ECC 0
`define IPCC_EV_ST_FAIL 1
`define IPCC_EV_SOFT 2
`define IPCC_EV_SA_DEACT 3
`define IPCC_EV_PSP_EXPIRE 4
`define IPCC_EV_W 5

// metadata control bits that ask for crypto processing
`define IPCC_MARK_MASK 8'h07
`define IPCC_MARK_VAL 8'h07

// egress protocol select
`define IPCC_PROTO_IPSEC 1'h0
`define IPCC_PROTO_PSP 1'h1

// widths of the iv fields
`define IPCC_SALT_W 32
`define IPCC_CNT_W 64

// reset values and counter constants
`define IPCC_ZERO32 32'h0
`define IPCC_ZERO64 64'h0
`define IPCC_ZERO96 96'h0
`define IPCC_CNT_MAX 64'hFFFFFFFFFFFFFFFF
`define IPCC_CNT_ONE 64'h1

// timing: clock rate and association lifetime in seconds
`define IPCC_CLK_HZ 64'd20000000
`define IPCC_SA_LIFE_S 64'd172800

`endif

// ==== rtl/ipcc_iv_gen.v ====
// Purpose: build a 96-bit gcm iv from a 32-bit salt and a sampled 64-bit counter
// Assumes: req is a level held by the caller until grant_q pulses
// Notes: with check_en high the iv is held back until the counter passes the last one used
`timescale 1ns/1ps
`include "ipcc_map.vh"

module ipcc_iv_gen #(
	parameter SALT_W = `IPCC_SALT_W,
	parameter CNT_W = `IPCC_CNT_W
) (
	input wire sys_clk,
	input wire reset_n,
	input wire en,
	input wire req,
	input wire check_en,
	input wire [SALT_W-1:0] salt,
	input wire [CNT_W-1:0] cnt,
	output reg grant_q,
	output reg [SALT_W+CNT_W-1:0] iv_q
);

	reg [CNT_W-1:0] last_q;
	wire fresh;
	wire take;

	// a counter-sampled iv is fresh only once the counter moved past the last one
	assign fresh = !check_en || (cnt > last_q);
	// grant_q guards against a second grant while the caller drops req
	assign take = en && req && fresh && !grant_q;

	// the iv is salt in the high word, counter in the low word
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			grant_q <= 1'h0;
			iv_q <= `IPCC_ZERO96;
			last_q <= `IPCC_ZERO64;
		end else begin
			grant_q <= take;
			if (take) begin
				iv_q <= {salt, cnt};
			end
			if (take && check_en) begin
				last_q <= cnt;
			end
		end
	end

endmodule

// ==== rtl/ipcc_top.v ====
// Purpose: per-packet crypto/bypass control, result flags, error freeze and iv build
// Assumes: one clock sys_clk at 20 MHz; aes datapaths and self-test engines sit outside
// Notes: valid/ready on each packet port; a register port for events, mask and salt
//
// How it works
// - metadata control bits of each packet choose crypto path or plaintext bypass.
// - unmarked ingress packet is bypassed and its crypto-applied flag reads 0.
// - marked egress packet processed successfully gets drop flag 0.
// - marked egress packet failing with soft error gets drop flag 1.
// - unmarked egress packet passes unprocessed with drop flag 0.
// - memory ecc failure raises fatal interrupt, hard error, frozen data outputs.
// - no crypto service before self-tests pass; a failure enters an error state.
// - every encryption iv is 32-bit salt field then 64-bit counter field.
// - key-wrap iv uses store salt and the entry-add counter, with the counter check on.
// - key-wrap and psp iv output stalls until the sampled counter exceeds the counter of the previous iv of the same kind (ipsec ivs leave it alone).
// - ipsec iv uses association salt and its 64-bit sequence number.
// - ipsec sequence number wrap deactivates the affected association.
// - psp iv uses association spi and a sample of the free-running timer.
// - psp associations live about two days, far below timer wrap.
// - reset clears all held salts and ivs to zero.
`timescale 1ns/1ps
`include "ipcc_map.vh"

module ipcc_top #(
	parameter CTRL_W = 8,
	parameter AW = 8,
	parameter [63:0] PSP_LIFE_TICKS = `IPCC_SA_LIFE_S * `IPCC_CLK_HZ
) (
	input wire sys_clk,
	input wire reset_n,
	// register port
	input wire [AW-1:0] reg_addr,
	input wire [31:0] reg_wdata,
	input wire reg_wr,
	input wire reg_rd,
	output reg [31:0] reg_rdata_q,
	output reg irq_q,
	output reg irq_fatal_q,
	// self-test engines and memory ecc checkers
	input wire st_done,
	input wire st_pass,
	input wire ecc_err,
	// ingress packets
	input wire in_valid,
	input wire [CTRL_W-1:0] in_meta_ctrl,
	output reg in_ready_q,
	output reg in_res_valid_q,
	output reg in_crypto_en_q,
	output reg in_crypto_applied_q,
	// egress packets
	input wire eg_valid,
	input wire [CTRL_W-1:0] eg_meta_ctrl,
	input wire eg_proto,
	input wire [31:0] eg_salt,
	input wire [63:0] eg_seq,
	input wire [63:0] eg_sa_birth,
	output reg eg_ready_q,
	output reg eg_res_valid_q,
	output reg eg_crypto_en_q,
	output reg eg_drop_q,
	output reg eg_sa_deact_q,
	// egress aes engine
	output reg eng_start_q,
	output reg [95:0] eng_iv_q,
	input wire eng_done,
	input wire eng_soft_err,
	// association store key wrap
	input wire store_add,
	input wire wrap_req,
	output wire wrap_grant_q,
	output wire [95:0] wrap_iv_q
);

	// block states
	localparam [1:0] S_TEST = 2'h0;
	localparam [1:0] S_RUN = 2'h1;
	localparam [1:0] S_FAIL = 2'h2;
	localparam [1:0] S_HARD = 2'h3;
	// egress states
	localparam [1:0] E_IDLE = 2'h0;
	localparam [1:0] E_IV = 2'h1;
	localparam [1:0] E_ENG = 2'h2;
	localparam [1:0] E_OUT = 2'h3;

	reg [1:0] sys_q, sys_d;
	reg [1:0] eg_st_q, eg_st_d;
	reg [`IPCC_EV_W-1:0] ev_q, ev_d, mask_q;
	reg [31:0] wrap_salt_q;
	reg [63:0] add_cnt_q, timer_q;
	reg eg_mark_q, eg_proto_q;
	reg [31:0] eg_salt_q;
	reg [63:0] eg_seq_q, eg_birth_q;
	reg eg_drop_d;
	reg ev_soft, ev_deact, ev_expire;
	wire run_now;
	wire eg_take;
	wire in_take;
	wire eg_iv_grant;
	wire [95:0] eg_iv;
	wire eg_expired;

	// shared decode of the crypto marking in a metadata record
	function is_marked;
		input [CTRL_W-1:0] ctrl;
		begin
			is_marked = ((ctrl & `IPCC_MARK_MASK) == `IPCC_MARK_VAL);
		end
	endfunction

	// an ecc error in this cycle already blocks any output taking effect
	assign run_now = (sys_q == S_RUN) && !ecc_err;
	assign in_take = in_valid && in_ready_q && run_now;
	assign eg_take = eg_valid && eg_ready_q && run_now && (eg_st_q == E_IDLE);
	// an expired psp association must not consume a timer sample or start the engine
	assign eg_expired = (eg_proto_q == `IPCC_PROTO_PSP) && (timer_q - eg_birth_q > PSP_LIFE_TICKS);

	// block state: hard error wins over everything and only reset leaves it
	always @* begin
		sys_d = sys_q;
		case (sys_q)
			S_TEST: begin
				if (st_done) begin
					sys_d = st_pass ? S_RUN : S_FAIL;
				end
			end
			S_RUN: sys_d = S_RUN;
			S_FAIL: sys_d = S_FAIL;
			S_HARD: sys_d = S_HARD;
			default: sys_d = S_HARD;
		endcase
		if (ecc_err) begin
			sys_d = S_HARD;
		end
	end

	// egress sequence: decide, build iv, wait for the engine, report
	always @* begin
		eg_st_d = eg_st_q;
		eg_drop_d = eg_drop_q;
		ev_soft = 1'h0;
		ev_deact = 1'h0;
		ev_expire = 1'h0;
		case (eg_st_q)
			E_IDLE: begin
				if (eg_take && !is_marked(eg_meta_ctrl)) begin
					eg_drop_d = 1'h0;
					eg_st_d = E_OUT;
				end else if (eg_take) begin
					eg_st_d = E_IV;
				end
			end
			E_IV: begin
				if (eg_iv_grant) begin
					eg_st_d = E_ENG;
				end else if (eg_expired) begin
					// an expired psp association never gets a fresh iv
					eg_drop_d = 1'h1;
					ev_expire = 1'h1;
					eg_st_d = E_OUT;
				end
			end
			E_ENG: begin
				if (eng_done) begin
					eg_drop_d = eng_soft_err;
					ev_soft = eng_soft_err;
					ev_deact = (eg_proto_q == `IPCC_PROTO_IPSEC) &&
						(eg_seq_q == `IPCC_CNT_MAX);
					eg_st_d = E_OUT;
				end
			end
			E_OUT: eg_st_d = run_now ? E_IDLE : E_OUT;
			default: eg_st_d = E_IDLE;
		endcase
	end

	// sticky events, set wins over a write-one-to-clear in the same cycle
	always @* begin
		ev_d = ev_q;
		if (reg_wr && reg_addr == `IPCC_A_EVENT) begin
			ev_d = ev_q & ~reg_wdata[`IPCC_EV_W-1:0];
		end
		if (ecc_err) begin
			ev_d[`IPCC_EV_ECC] = 1'h1;
		end
		if (sys_q == S_TEST && st_done && !st_pass) begin
			ev_d[`IPCC_EV_ST_FAIL] = 1'h1;
		end
		if (ev_soft) begin
			ev_d[`IPCC_EV_SOFT] = 1'h1;
		end
		if (ev_deact) begin
			ev_d[`IPCC_EV_SA_DEACT] = 1'h1;
		end
		if (ev_expire) begin
			ev_d[`IPCC_EV_PSP_EXPIRE] = 1'h1;
		end
	end

	// state, events, registers and counters
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sys_q <= S_TEST;
			ev_q <= {`IPCC_EV_W{1'h0}};
			mask_q <= {`IPCC_EV_W{1'h0}};
			wrap_salt_q <= `IPCC_ZERO32;
			add_cnt_q <= `IPCC_ZERO64;
			timer_q <= `IPCC_ZERO64;
			irq_q <= 1'h0;
			irq_fatal_q <= 1'h0;
			reg_rdata_q <= `IPCC_ZERO32;
		end else begin
			sys_q <= sys_d;
			ev_q <= ev_d;
			irq_q <= |(ev_d & mask_q);
			irq_fatal_q <= (sys_d == S_HARD);
			timer_q <= timer_q + `IPCC_CNT_ONE; // free-running, wraps after ~29000 years
			if (store_add) begin
				add_cnt_q <= add_cnt_q + `IPCC_CNT_ONE;
			end
			if (reg_wr && reg_addr == `IPCC_A_MASK) begin
				mask_q <= reg_wdata[`IPCC_EV_W-1:0];
			end
			if (reg_wr && reg_addr == `IPCC_A_WRAP_SALT) begin
				wrap_salt_q <= reg_wdata;
			end
			// read data stand only in the cycle after the strobe
			reg_rdata_q <= `IPCC_ZERO32;
			if (reg_rd) begin
				case (reg_addr)
					`IPCC_A_EVENT: reg_rdata_q <= {{(32-`IPCC_EV_W){1'h0}}, ev_q};
					`IPCC_A_MASK: reg_rdata_q <= {{(32-`IPCC_EV_W){1'h0}}, mask_q};
					`IPCC_A_STATE: reg_rdata_q <= {30'h0, sys_q};
					`IPCC_A_ADD_LO: reg_rdata_q <= add_cnt_q[31:0];
					`IPCC_A_ADD_HI: reg_rdata_q <= add_cnt_q[63:32];
					// the salt is secret: write-only, reads zero
					default: reg_rdata_q <= `IPCC_ZERO32;
				endcase
			end
		end
	end

	// ingress decision is made in the cycle the packet is taken
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			in_ready_q <= 1'h0;
			in_res_valid_q <= 1'h0;
			in_crypto_en_q <= 1'h0;
			in_crypto_applied_q <= 1'h0;
		end else begin
			in_ready_q <= (sys_d == S_RUN);
			in_res_valid_q <= in_take;
			if (in_take) begin
				in_crypto_en_q <= is_marked(in_meta_ctrl);
				in_crypto_applied_q <= is_marked(in_meta_ctrl);
			end
		end
	end

	// egress packet latch and result outputs; nothing leaves once frozen
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			eg_st_q <= E_IDLE;
			eg_ready_q <= 1'h0;
			eg_res_valid_q <= 1'h0;
			eg_crypto_en_q <= 1'h0;
			eg_drop_q <= 1'h0;
			eg_sa_deact_q <= 1'h0;
			eng_start_q <= 1'h0;
			eng_iv_q <= `IPCC_ZERO96;
			eg_mark_q <= 1'h0;
			eg_proto_q <= `IPCC_PROTO_IPSEC;
			eg_salt_q <= `IPCC_ZERO32;
			eg_seq_q <= `IPCC_ZERO64;
			eg_birth_q <= `IPCC_ZERO64;
		end else begin
			eg_st_q <= eg_st_d;
			eg_drop_q <= eg_drop_d;
			eg_ready_q <= (eg_st_d == E_IDLE) && (sys_d == S_RUN);
			eg_res_valid_q <= (eg_st_q == E_OUT) && run_now;
			eg_sa_deact_q <= ev_deact && run_now;
			eng_start_q <= eg_iv_grant && run_now;
			if (eg_iv_grant) begin
				eng_iv_q <= eg_iv;
			end
			if (eg_take) begin
				eg_mark_q <= is_marked(eg_meta_ctrl);
				eg_crypto_en_q <= is_marked(eg_meta_ctrl);
				eg_proto_q <= eg_proto;
				eg_salt_q <= eg_salt;
				eg_seq_q <= eg_seq;
				eg_birth_q <= eg_sa_birth;
			end
		end
	end

	// egress iv: psp samples the timer and must see it advance; ipsec takes the
	// sequence number as given, since its uniqueness comes from rollover retirement
	ipcc_iv_gen u_eg_iv (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.en(run_now),
		.req((eg_st_q == E_IV) && eg_mark_q && !eg_expired),
		.check_en(eg_proto_q == `IPCC_PROTO_PSP),
		.salt(eg_salt_q),
		.cnt((eg_proto_q == `IPCC_PROTO_PSP) ? timer_q : eg_seq_q),
		.grant_q(eg_iv_grant),
		.iv_q(eg_iv)
	);

	// key-wrap iv from the store salt and the entry-add counter
	ipcc_iv_gen u_wrap_iv (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.en(run_now),
		.req(wrap_req),
		.check_en(1'h1),
		.salt(wrap_salt_q),
		.cnt(add_cnt_q),
		.grant_q(wrap_grant_q),
		.iv_q(wrap_iv_q)
	);

endmodule

// ==== bench/ipcc_checker.sv ====
// Purpose: port-level assertions for the packet crypto control block
// Assumes: one clock domain; sees only the top module's ports
// Notes: small helper state captures what each output is judged against
`timescale 1ns/1ps
`include "ipcc_map.vh"
module ipcc_checker (
	input logic sys_clk,
	input logic reset_n,
	input logic st_done,
	input logic st_pass,
	input logic ecc_err,
	input logic in_valid,
	input logic [7:0] in_meta_ctrl,
	input logic in_ready_q,
	input logic in_res_valid_q,
	input logic in_crypto_en_q,
	input logic in_crypto_applied_q,
	input logic eg_valid,
	input logic eg_proto,
	input logic [31:0] eg_salt,
	input logic [63:0] eg_seq,
	input logic eg_ready_q,
	input logic eg_res_valid_q,
	input logic eg_crypto_en_q,
	input logic eg_drop_q,
	input logic eg_sa_deact_q,
	input logic eng_start_q,
	input logic [95:0] eng_iv_q,
	input logic eng_done,
	input logic eng_soft_err,
	input logic wrap_grant_q,
	input logic [95:0] wrap_iv_q,
	input logic irq_fatal_q
);
	logic ok_q, seen_q, wait_q, cp_q;
	logic [95:0] cap_q;
	logic [63:0] wlast_q;
	// self-test verdict, engine wait, fields of the last egress take, last wrap counter
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			{ok_q, seen_q, wait_q, cp_q, cap_q, wlast_q} <= '0;
		end else begin
			if (st_done && !seen_q) begin
				seen_q <= 1'h1;
				ok_q <= st_pass;
			end
			if (eng_start_q) wait_q <= 1'h1;
			else if (eng_done) wait_q <= 1'h0;
			if (eg_valid && eg_ready_q) begin
				cp_q <= eg_proto;
				cap_q <= {eg_salt, eg_seq};
			end
			if (wrap_grant_q) wlast_q <= wrap_iv_q[63:0];
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	sequence s_take_in;
		in_valid && in_ready_q && !ecc_err && !irq_fatal_q;
	endsequence
	sequence s_eg_out;
		##2 (eg_res_valid_q && eg_drop_q == $past(eng_soft_err, 2));
	endsequence
	a_in_answer: assert property (s_take_in |=> in_res_valid_q)
		else $error("ingress result missing");
	a_in_flag_mark: assert property (in_res_valid_q |-> in_crypto_en_q == in_crypto_applied_q
		&& in_crypto_applied_q == (($past(in_meta_ctrl) & `IPCC_MARK_MASK) == `IPCC_MARK_VAL))
		else $error("ingress crypto flag wrong");
	a_eg_soft_drop: assert property (wait_q && eng_done && !ecc_err |-> s_eg_out)
		else $error("egress drop flag wrong");
	a_eg_bypass: assert property (eg_res_valid_q && !eg_crypto_en_q |-> !eg_drop_q)
		else $error("bypass packet dropped");
	a_ipsec_iv: assert property (eng_start_q && !cp_q |-> eng_iv_q == cap_q)
		else $error("ipsec iv wrong");
	a_psp_spi: assert property (eng_start_q && cp_q |-> eng_iv_q[95:64] == cap_q[95:64])
		else $error("psp iv salt field wrong");
	a_wrap_unique: assert property (wrap_grant_q |-> wrap_iv_q[63:0] > wlast_q)
		else $error("wrap iv counter not increasing");
	a_sa_deact: assert property (eg_sa_deact_q |-> !cp_q && cap_q[63:0] == `IPCC_CNT_MAX)
		else $error("deactivation without wrap");
	a_ready_gated: assert property (in_ready_q || eg_ready_q |-> ok_q)
		else $error("service before self-test pass");
	a_fatal_raise: assert property (ecc_err |=> irq_fatal_q [*2])
		else $error("fatal interrupt missing");
	a_fatal_hold: assert property (irq_fatal_q |=> irq_fatal_q)
		else $error("fatal state left");
	a_freeze_out: assert property (irq_fatal_q && $past(irq_fatal_q) |-> !(in_res_valid_q
		|| eg_res_valid_q || eng_start_q || wrap_grant_q || in_ready_q || eg_ready_q))
		else $error("output while frozen");
	a_reset_clear: assert property (disable iff (1'b0) !reset_n |-> eng_iv_q == '0
		&& wrap_iv_q == '0 && !irq_fatal_q)
		else $error("secret not cleared in reset");
endmodule
bind ipcc_top ipcc_checker ipcc_checker_i (.*);

// ==== bench/ipcc_proc_model.sv ====
// Purpose: upstream ingress and egress packet processors
// Assumes: offer is entered from a process that has just left a clock edge
// Notes: fields turn to their inverse once an offer ends, taken or timed out, so stale data never looks valid
`timescale 1ns/1ps
module ipcc_proc_model (
	input logic sys_clk,
	input logic in_ready_q,
	input logic eg_ready_q,
	output logic in_valid = 1'h0,
	output logic [7:0] in_meta_ctrl = 8'h00,
	output logic eg_valid = 1'h0,
	output logic [7:0] eg_meta_ctrl = 8'h00,
	output logic eg_proto = 1'h0,
	output logic [31:0] eg_salt = 32'h0,
	output logic [63:0] eg_seq = 64'h0,
	output logic [63:0] eg_sa_birth = 64'h0
);
	// packet and metadata go as one unit, held until ready is seen at an edge
	task automatic offer(input bit eg, input logic [7:0] c, input logic [160:0] f, output bit ok);
		int n;
		ok = 1'b0;
		@(posedge sys_clk);
		if (eg) begin
			eg_valid <= 1'h1;
			eg_meta_ctrl <= c;
			{eg_proto, eg_salt, eg_seq, eg_sa_birth} <= f;
		end else begin
			in_valid <= 1'h1;
			in_meta_ctrl <= c;
		end
		// ready is read mid-cycle, where it is settled for the coming edge
		for (n = 0; n < 60 && !ok; n++) begin
			@(negedge sys_clk);
			ok = eg ? eg_ready_q : in_ready_q;
			@(posedge sys_clk);
		end
		in_valid <= 1'h0;
		eg_valid <= 1'h0;
		if (eg) {eg_proto, eg_salt, eg_seq, eg_sa_birth} <= ~f;
		if (eg) eg_meta_ctrl <= ~c;
		else in_meta_ctrl <= ~c;
	endtask
endmodule

// ==== bench/tb_inline_packet_crypto_control.sv ====
// Purpose: self-checking bench of the packet crypto control block
// Assumes: 20 MHz clock; psp lifetime shortened to 100 ticks
// Notes: outputs are sampled at the falling edge or 1 ns after the rising edge, inputs driven at the rising edge
`timescale 1ns/1ps
`include "ipcc_map.vh"
module tb_inline_packet_crypto_control;
	logic sys_clk = 1'h0, reset_n = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, st_done = 1'h0;
	logic st_pass = 1'h0, ecc_err = 1'h0, eng_done = 1'h0, eng_soft_err = 1'h0;
	logic store_add = 1'h0, wrap_req = 1'h0, soft_v = 1'h0, deact_seen = 1'h0;
	logic [7:0] reg_addr = 8'h00, in_meta_ctrl, eg_meta_ctrl;
	logic [31:0] reg_wdata = 32'h0, reg_rdata_q, eg_salt;
	logic irq_q, irq_fatal_q, in_valid, in_ready_q, in_res_valid_q, in_crypto_en_q;
	logic in_crypto_applied_q, eg_valid, eg_proto, eg_ready_q, eg_res_valid_q, eg_crypto_en_q;
	logic eg_drop_q, eg_sa_deact_q, eng_start_q, wrap_grant_q;
	logic [63:0] eg_seq, eg_sa_birth, cyc = 64'h0;
	logic [95:0] eng_iv_q, wrap_iv_q;
	int n_fail = 0, cmp_count = 0, n_grant = 0;
	ipcc_top #(.PSP_LIFE_TICKS(64'h64)) ipcc_top_i (.*);
	ipcc_proc_model ipcc_proc_model_i (.*);
	initial forever #25 sys_clk = ~sys_clk;
	// cycle count since reset release stands in for the master timer
	always @(posedge sys_clk) cyc <= reset_n ? cyc + 64'h1 : 64'h0;
	// pulse watchers sampled mid-cycle
	always @(negedge sys_clk) begin
		if (eg_sa_deact_q === 1'h1) deact_seen <= 1'h1;
		if (wrap_grant_q === 1'h1) n_grant++;
	end
	// aes engine stand-in: answers a start after 1 to 4 cycles
	initial forever begin
		@(negedge sys_clk);
		if (eng_start_q === 1'h1) begin
			repeat ($urandom_range(3, 0)) @(posedge sys_clk);
			@(posedge sys_clk);
			eng_done <= 1'h1;
			eng_soft_err <= soft_v;
			@(posedge sys_clk);
			eng_done <= 1'h0;
			eng_soft_err <= ~soft_v;
		end
	end
	task automatic end_sim();
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic check(input string what, input logic [95:0] seen, input logic [95:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'h1};
		@(posedge sys_clk);
		reg_wr <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
		@(posedge sys_clk);
		{reg_addr, reg_rd} <= {a, 1'h1};
		@(posedge sys_clk);
		reg_rd <= 1'h0;
		#1 check(what, reg_rdata_q, exp);
	endtask
	// bounded wait on one of the result pulses
	task automatic wait_on(input int k, input int n);
		logic [2:0] v;
		for (int i = 0; i < n; i++) begin
			@(negedge sys_clk);
			v = {wrap_grant_q, eg_res_valid_q, in_res_valid_q};
			if (v[k] === 1'h1) return;
		end
		n_fail++;
		$display("CHECK FAILED wait %0d expected 1 seen 0", k);
		end_sim();
	endtask
	function automatic logic f_mark(input logic [7:0] c);
		return (c & `IPCC_MARK_MASK) == `IPCC_MARK_VAL;
	endfunction
	task automatic pulse_add();
		@(posedge sys_clk) store_add <= 1'h1;
		@(posedge sys_clk) store_add <= 1'h0;
	endtask
	initial begin
		bit ok;
		logic [7:0] c;
		logic [31:0] sl;
		logic [63:0] s;
		int seed;
		// a falling reset at time zero clears the design before the first clock edge
		reset_n <= 1'h0;
		seed = $urandom(32'h9A48);
		repeat (20) @(posedge sys_clk);
		reset_n <= 1'h1;
		repeat (3) @(negedge sys_clk);
		check("ready_pre", {in_ready_q, eg_ready_q}, 2'h0);
		rd(`IPCC_A_STATE, 32'h0, "state_test");
		@(posedge sys_clk) {st_done, st_pass} <= 2'h3;
		@(posedge sys_clk) {st_done, st_pass} <= 2'h0;
		rd(`IPCC_A_STATE, 32'h1, "state_run");
		rd(`IPCC_A_MASK, 32'h0, "mask_reset");
		wr(`IPCC_A_WRAP_SALT, 32'h5A17C0DE);
		rd(`IPCC_A_WRAP_SALT, 32'h0, "salt_wo");
		rd(8'h20, 32'h0, "unmapped");
		wr(`IPCC_A_MASK, 32'h4);
		for (int i = 0; i < 24; i++) begin
			c = (i == 0) ? 8'h07 : (i == 1) ? 8'h03 : 8'($urandom);
			ipcc_proc_model_i.offer(1'b0, c, 161'h0, ok);
			wait_on(0, 5);
			check("crypto_applied", in_crypto_applied_q, f_mark(c));
		end
		for (int i = 0; i < 6; i++) begin
			c = (i == 0) ? 8'h00 : 8'hF7;
			s = (i == 3) ? `IPCC_CNT_MAX : {32'($urandom), 32'($urandom)};
			sl = $urandom;
			soft_v = (i == 2);
			if (i == 5) repeat (250) @(posedge sys_clk);
			ipcc_proc_model_i.offer(1'b1, c, {i >= 4, sl, s, (i == 5) ? 64'h0 : cyc}, ok);
			wait_on(1, 40);
			check("drop", eg_drop_q, i == 2 || i == 5);
			check("eg_crypto_en", eg_crypto_en_q, i != 0);
			if (i == 1 || i == 2) check("ipsec_iv", eng_iv_q, {sl, s});
			if (i == 4) check("psp_spi", eng_iv_q[95:64], sl);
		end
		check("sa_deact", deact_seen, 1'h1);
		check("irq_on", irq_q, 1'h1);
		rd(`IPCC_A_EVENT, 32'h1C, "events");
		wr(`IPCC_A_EVENT, 32'h4);
		#1 check("irq_clear", irq_q, 1'h0);
		wr(`IPCC_A_MASK, 32'h10);
		// the new mask reaches the registered interrupt one edge after the write
		repeat (2) @(negedge sys_clk);
		check("irq_mask", irq_q, 1'h1);
		wr(`IPCC_A_EVENT, 32'h18);
		rd(`IPCC_A_EVENT, 32'h0, "events_clr");
		check("irq_off", irq_q, 1'h0);
		// key wrap: first grant needs one add, a second stalls until the next add
		pulse_add();
		@(posedge sys_clk) wrap_req <= 1'h1;
		wait_on(2, 10);
		check("wrap_iv", wrap_iv_q, {32'h5A17C0DE, 64'h1});
		repeat (8) @(posedge sys_clk);
		check("wrap_stall", n_grant, 1);
		pulse_add();
		wait_on(2, 10);
		check("wrap_iv2", wrap_iv_q, {32'h5A17C0DE, 64'h2});
		@(posedge sys_clk) wrap_req <= 1'h0;
		rd(`IPCC_A_ADD_LO, 32'h2, "add_lo");
		@(posedge sys_clk) ecc_err <= 1'h1;
		@(posedge sys_clk) ecc_err <= 1'h0;
		repeat (2) @(negedge sys_clk);
		check("fatal", {irq_fatal_q, in_ready_q}, 2'h2);
		ipcc_proc_model_i.offer(1'b0, 8'h07, 161'h0, ok);
		check("frozen", ok, 1'h0);
		rd(`IPCC_A_STATE, 32'h3, "state_hard");
		@(posedge sys_clk) reset_n <= 1'h0;
		repeat (2) @(negedge sys_clk);
		check("zeroed", {eng_iv_q, wrap_iv_q, irq_fatal_q} == '0, 1'h1);
		end_sim();
	end
endmodule
